// [design/lpp_pkg.sv]
/*
  lpp_pkg: shared constants and carrier types for the light/proximity
  power and sequencing block.
  assumes: one 100 MHz system clock; registers reached over the device's
  two-wire target port.
*/
package lpp_pkg;

  // clock rate and derived timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned ALS_WINDOW_MS   = 100;   // integration window
  localparam int unsigned LED_PULSE_US_X10 = 1;    // 0.1 ms led drive, in 100 us units
  localparam int unsigned ALS_WINDOW_CYC  = (CLK_HZ / 1000) * ALS_WINDOW_MS;
  localparam int unsigned LED_PULSE_CYC   = (CLK_HZ / 10000) * LED_PULSE_US_X10;
  localparam int unsigned PROX_SLEEP_UNIT_CYC = CLK_HZ / 10; // 100 ms per sleep step

  // target address, fixed
  localparam logic [6:0] TARGET_ADDR = 7'h44;

  // register offsets
  localparam logic [7:0] SENSING_CONFIGURATION_OFS = 8'h01;
  localparam logic [7:0] TEST_CONTROL_ONE_OFS      = 8'h0E;
  localparam logic [7:0] TEST_CONTROL_TWO_OFS      = 8'h0F;

  // reset values
  localparam logic [7:0] SENSING_CONFIGURATION_RST = 8'h00;
  localparam logic [7:0] TEST_CONTROL_RST          = 8'h00;

  // field positions in sensing_configuration
  localparam int unsigned PROX_EN_BIT   = 7;
  localparam int unsigned PROX_SLEEP_LSB = 4;
  localparam int unsigned PROX_DRIVE_BIT = 3;
  localparam int unsigned ALS_EN_BIT    = 2;
  localparam int unsigned ALS_RANGE_BIT = 1;
  localparam int unsigned VIS_IR_BIT    = 0;

  // decoded configuration carrier
  typedef struct packed {
    logic       prox_en;
    logic [2:0] prox_sleep;
    logic       prox_drive_hi;
    logic       als_en;
    logic       als_range_hi;
    logic       visible_or_infrared_select;
  } lpp_cfg_t;

  // i2c target states
  typedef enum logic [5:0] {
    I2C_IDLE = 6'b000001,
    I2C_ADDR = 6'b000010,
    I2C_ACK  = 6'b000100,
    I2C_WR   = 6'b001000,
    I2C_RD   = 6'b010000,
    I2C_RACK = 6'b100000
  } lpp_i2c_st_t;

endpackage

// [design/lpp_power_init_control.sv]
/*
  lpp_power_init_control: register file behind the two-wire target port,
  power-down control, als window timing and led pulse timing.
  assumes: scl/sda arrive asynchronous and are synchronised here; the
  analog front end consumes the conversion strobes and range select.
*/
//
// Overview of operation
// - both enables clear means power-down
// - all-zero config write forces power-down
// - range bit selects lux per count scale
// - als conversion integrates over 100 ms
// - answer only at fixed address 1000100
// - led driven 0.1 ms per prox measurement
`timescale 1ns/10ps
`default_nettype none

module lpp_power_init_control
  import lpp_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // two-wire target pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_b,
  // sensing outputs
  output logic      led_drive_pin,
  output logic      led_drive_hi,
  output logic      als_range_hi,
  output logic      visible_or_infrared_select,
  output logic      als_conv_start,
  output logic      prox_conv_start,
  output logic      powered_down,
  output logic      reinit_seen
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync_reg;   // [0] first stage only feeds [1]
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;      // previous synchronised level
  logic       sda_d_reg;

  // two stages before anything reads the pins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////
  // two-wire target state
  lpp_i2c_st_t st_reg, st_next;       // protocol state
  logic [7:0]  sh_reg, sh_next;       // shift register
  logic [3:0]  bit_reg, bit_next;     // bit count in byte
  logic [7:0]  ptr_reg, ptr_next;     // register pointer
  logic        ptr_ok_reg, ptr_ok_next; // pointer byte received
  logic        ack_reg, ack_next;     // pulling sda low
  logic        rnw_reg, rnw_next;     // read transaction
  logic        drv_reg, drv_next;     // read data bit drive low
  logic [7:0]  cfg_reg, cfg_next;     // sensing_configuration
  logic [7:0]  t1_reg, t1_next;       // test_control_one
  logic [7:0]  t2_reg, t2_next;       // test_control_two
  logic        wr_stb;                // completed data byte write
  logic [7:0]  rd_val;                // read mux

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ptr_reg)
      SENSING_CONFIGURATION_OFS: rd_val = cfg_reg;
      TEST_CONTROL_ONE_OFS:      rd_val = t1_reg;
      TEST_CONTROL_TWO_OFS:      rd_val = t2_reg;
      default:                   rd_val = 8'h00;
    endcase
  end

  // protocol next-state
  always_comb begin
    st_next     = st_reg;
    sh_next     = sh_reg;
    bit_next    = bit_reg;
    ptr_next    = ptr_reg;
    ptr_ok_next = ptr_ok_reg;
    ack_next    = ack_reg;
    rnw_next    = rnw_reg;
    drv_next    = drv_reg;
    cfg_next    = cfg_reg;
    t1_next     = t1_reg;
    t2_next     = t2_reg;
    wr_stb      = 1'b0;
    if (stop_c) begin
      // stop releases the bus
      st_next  = I2C_IDLE;
      ack_next = 1'b0;
      drv_next = 1'b0;
    end else if (start_c) begin
      // start or repeated start
      st_next     = I2C_ADDR;
      bit_next    = 4'h0;
      ptr_ok_next = 1'b0;
      ack_next    = 1'b0;
      drv_next    = 1'b0;
    end else begin
      case (st_reg)
        I2C_IDLE: begin
          ack_next = 1'b0;
        end
        I2C_ADDR, I2C_WR: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            if (st_reg == I2C_ADDR) begin
              if (sh_reg[7:1] == TARGET_ADDR) begin
                ack_next = 1'b1;
                rnw_next = sh_reg[0];
                st_next  = I2C_ACK;
              end else begin
                st_next = I2C_IDLE;
              end
            end else begin
              ack_next = 1'b1;
              st_next  = I2C_ACK;
              if (!ptr_ok_reg) begin
                ptr_next    = sh_reg;
                ptr_ok_next = 1'b1;
              end else begin
                wr_stb   = 1'b1;
                ptr_next = ptr_reg + 8'h01;
                case (ptr_reg)
                  SENSING_CONFIGURATION_OFS: cfg_next = sh_reg;
                  TEST_CONTROL_ONE_OFS:      t1_next  = sh_reg;
                  TEST_CONTROL_TWO_OFS:      t2_next  = sh_reg;
                  default:                   cfg_next = cfg_reg;
                endcase
              end
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            ack_next = 1'b0;
            if (rnw_reg) begin
              st_next  = I2C_RD;
              sh_next  = rd_val;
              drv_next = ~rd_val[7];
              bit_next = 4'h0;
              ptr_next = ptr_reg + 8'h01;
            end else begin
              st_next = I2C_WR;
            end
          end
        end
        I2C_RD: begin
          if (scl_fall) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              drv_next = 1'b0;
              st_next  = I2C_RACK;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0};
              drv_next = ~sh_reg[6];
            end
          end
        end
        I2C_RACK: begin
          // host ack continues, nack ends the read
          if (scl_rise) begin
            rnw_next = ~sda_s;
          end else if (scl_fall) begin
            if (rnw_reg) begin
              st_next  = I2C_RD;
              sh_next  = rd_val;
              drv_next = ~rd_val[7];
              bit_next = 4'h0;
              ptr_next = ptr_reg + 8'h01;
            end else begin
              st_next = I2C_IDLE;
            end
          end
        end
        default: st_next = I2C_IDLE;
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= I2C_IDLE;
      sh_reg     <= 8'h00;
      bit_reg    <= 4'h0;
      ptr_reg    <= 8'h00;
      ptr_ok_reg <= 1'b0;
      ack_reg    <= 1'b0;
      rnw_reg    <= 1'b0;
      drv_reg    <= 1'b0;
      cfg_reg    <= SENSING_CONFIGURATION_RST;
      t1_reg     <= TEST_CONTROL_RST;
      t2_reg     <= TEST_CONTROL_RST;
    end else begin
      st_reg     <= st_next;
      sh_reg     <= sh_next;
      bit_reg    <= bit_next;
      ptr_reg    <= ptr_next;
      ptr_ok_reg <= ptr_ok_next;
      ack_reg    <= ack_next;
      rnw_reg    <= rnw_next;
      drv_reg    <= drv_next;
      cfg_reg    <= cfg_next;
      t1_reg     <= t1_next;
      t2_reg     <= t2_next;
    end
  end

  // open-drain: only ever pull low, enable low while pulling
  assign sda_out  = 1'b0;
  assign sda_oe_b = ~(ack_reg | drv_reg);

  ////////////////////////////////////////////////////////////////////
  // reinit sequence tracker: host's job, observed for status only
  logic [1:0] seq_reg, seq_next;   // sequence step reached
  logic       seen_reg, seen_next; // full sequence observed

  always_comb begin
    seq_next  = seq_reg;
    seen_next = seen_reg;
    if (wr_stb) begin
      seq_next = 2'h0;
      case (seq_reg)
        2'h0: if (ptr_reg == SENSING_CONFIGURATION_OFS && sh_reg == 8'h00) seq_next = 2'h1;
        2'h1: if (ptr_reg == TEST_CONTROL_TWO_OFS && sh_reg == 8'h29) seq_next = 2'h2;
        2'h2: if (ptr_reg == TEST_CONTROL_ONE_OFS && sh_reg == 8'h00) seq_next = 2'h3;
        default: if (ptr_reg == TEST_CONTROL_TWO_OFS && sh_reg == 8'h00) seen_next = 1'b1;
      endcase
      // any other write after completion clears the mark
      if (seq_reg != 2'h3 && seen_reg) seen_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg  <= 2'h0;
      seen_reg <= 1'b0;
    end else begin
      seq_reg  <= seq_next;
      seen_reg <= seen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sensing control
  lpp_cfg_t cfg;
  assign cfg = lpp_cfg_t'(cfg_reg);

  logic pd;
  assign pd = ~cfg.prox_en & ~cfg.als_en;

  logic [23:0] als_cnt_reg, als_cnt_next;   // als window counter
  logic [31:0] prox_cnt_reg, prox_cnt_next; // prox period counter
  logic [15:0] led_cnt_reg, led_cnt_next;   // led pulse remaining
  logic        als_stb, prox_stb;
  logic [31:0] prox_period;

  // sleep steps of 100 ms, one step minimum
  assign prox_period = PROX_SLEEP_UNIT_CYC * (32'(cfg.prox_sleep) + 32'd1);

  // timer next values
  always_comb begin
    als_cnt_next  = als_cnt_reg;
    prox_cnt_next = prox_cnt_reg;
    led_cnt_next  = led_cnt_reg;
    als_stb       = 1'b0;
    prox_stb      = 1'b0;
    if (!cfg.als_en) begin
      als_cnt_next = 24'h000000;
    end else if (als_cnt_reg == 24'(ALS_WINDOW_CYC - 1)) begin
      als_cnt_next = 24'h000000;
      als_stb      = 1'b1;
    end else begin
      als_cnt_next = als_cnt_reg + 24'h000001;
    end
    // no new prox starts when disabled
    if (!cfg.prox_en) begin
      prox_cnt_next = 32'h00000000;
      led_cnt_next  = 16'h0000;
    end else begin
      if (prox_cnt_reg == 32'h00000000) prox_stb = 1'b1;
      if (prox_cnt_reg >= prox_period - 32'd1) prox_cnt_next = 32'h00000000;
      else prox_cnt_next = prox_cnt_reg + 32'h00000001;
      // 0.1 ms led pulse per measurement
      if (prox_stb) led_cnt_next = 16'(LED_PULSE_CYC);
      else if (led_cnt_reg != 16'h0000) led_cnt_next = led_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      als_cnt_reg     <= 24'h000000;
      prox_cnt_reg    <= 32'h00000000;
      led_cnt_reg     <= 16'h0000;
      led_drive_pin   <= 1'b0;
      als_conv_start  <= 1'b0;
      prox_conv_start <= 1'b0;
      powered_down    <= 1'b1;
    end else begin
      als_cnt_reg     <= als_cnt_next;
      prox_cnt_reg    <= prox_cnt_next;
      led_cnt_reg     <= led_cnt_next;
      led_drive_pin   <= (led_cnt_next != 16'h0000);
      als_conv_start  <= als_stb;
      prox_conv_start <= prox_stb;
      powered_down    <= pd;
    end
  end

  assign als_range_hi               = cfg.als_range_hi;
  assign visible_or_infrared_select = cfg.visible_or_infrared_select;
  assign led_drive_hi               = cfg.prox_drive_hi;
  assign reinit_seen                = seen_reg;

endmodule
`default_nettype wire

// [verification/lpp_power_init_control_sva.sv]
/* checker for power-down, led pulse, als period and sda timing.
   assumes: bound to lpp_power_init_control, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module lpp_power_init_control_sva
  import lpp_pkg::*;
(
  // watched ports
  input wire logic clk_sys, rst_b, scl_in, sda_in, sda_out, sda_oe_b,
  input wire logic led_drive_pin, led_drive_hi, als_range_hi, visible_or_infrared_select,
  input wire logic als_conv_start, prox_conv_start, powered_down, reinit_seen
);
  int unsigned led_cnt; // cycles led held high
  int unsigned als_cnt; // cycles since last als strobe
  logic        als_seen; // a first strobe has set the phase
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      led_cnt  <= 0;
      als_cnt  <= 0;
      als_seen <= 1'b0;
    end else begin
      led_cnt  <= led_drive_pin ? led_cnt + 1 : 0;
      als_cnt  <= als_conv_start ? 0 : als_cnt + 1;
      als_seen <= (als_seen | als_conv_start) & !powered_down;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pd_no_conv: assert property (powered_down |-> !als_conv_start && !prox_conv_start)
    else $error("conversion while powered down");
  a_led_not_pd: assert property ($rose(led_drive_pin) |-> !powered_down)
    else $error("led pulse while powered down");
  a_prox_led_start: assert property (prox_conv_start |-> ##[0:3] led_drive_pin)
    else $error("prox start without led drive");
  a_led_width: assert property ($fell(led_drive_pin) |-> led_cnt == LED_PULSE_CYC)
    else $error("led pulse width wrong");
  a_prox_one_cycle: assert property (prox_conv_start |=> !prox_conv_start)
    else $error("prox strobe longer than one cycle");
  a_als_one_cycle: assert property (als_conv_start |=> !als_conv_start)
    else $error("als strobe longer than one cycle");
  a_als_window: assert property (als_conv_start && als_seen |-> als_cnt == ALS_WINDOW_CYC - 1)
    else $error("als window length wrong");
  a_sda_scl_low: assert property ($changed(sda_oe_b) |-> !scl_in)
    else $error("sda moved while scl high");
endmodule
bind lpp_power_init_control lpp_power_init_control_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .led_drive_pin(led_drive_pin),
  .led_drive_hi(led_drive_hi), .als_range_hi(als_range_hi), .visible_or_infrared_select(visible_or_infrared_select),
  .als_conv_start(als_conv_start), .prox_conv_start(prox_conv_start), .powered_down(powered_down),
  .reinit_seen(reinit_seen));
`default_nettype wire

// [verification/lpp_host_model.sv]
/* two-wire bus controller standing in for the host.
   assumes: sda_line is the resolved wire with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module lpp_host_model
  import lpp_pkg::*;
#(parameter int unsigned Q = 10)
(
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // start, also used as repeated start
  task automatic start_c();
    sda_drv = 1'b1; tick(Q); scl_drv = 1'b1; tick(Q); sda_drv = 1'b0; tick(Q); scl_drv = 1'b0; tick(Q);
  endtask
  task automatic stop_c();
    sda_drv = 1'b0; tick(Q); scl_drv = 1'b1; tick(Q); sda_drv = 1'b1; tick(Q);
  endtask
  // one bit out, wire sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b; tick(Q); scl_drv = 1'b1; tick(Q); r = sda_line; tick(Q); scl_drv = 1'b0; tick(Q);
  endtask
  // msb first, ninth bit released: ack from device, nack from host
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start_c(); byte_io({a, 1'b0}, r, k1); byte_io(o, r, k2); byte_io(d, r, k3); stop_c();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start_c(); byte_io({TARGET_ADDR, 1'b0}, r, k); byte_io(o, r, k);
    start_c(); byte_io({TARGET_ADDR, 1'b1}, r, k); byte_io(8'hFF, d, k); stop_c();
  endtask
  task automatic reinit();
    logic ok;
    wr(TARGET_ADDR, SENSING_CONFIGURATION_OFS, 8'h00, ok);
    wr(TARGET_ADDR, TEST_CONTROL_TWO_OFS, 8'h29, ok);
    wr(TARGET_ADDR, TEST_CONTROL_ONE_OFS, 8'h00, ok);
    wr(TARGET_ADDR, TEST_CONTROL_TWO_OFS, 8'h00, ok);
    tick(CLK_HZ / 1000);
  endtask
endmodule
`default_nettype wire

// [verification/tb_light_prox_power_init_control.sv]
/* self-checking bench: reinit, config decode, address filter, led pulse.
   assumes: host model drives the bus, pull-up on sda. */
`timescale 1ns/10ps
`default_nettype none
module tb_light_prox_power_init_control;
  import lpp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic scl_drv, sda_drv, sda_out, sda_oe_b, led_drive_pin, led_drive_hi, als_range_hi;
  logic visible_or_infrared_select, als_conv_start, prox_conv_start, powered_down, reinit_seen;
  wire logic sda_line = sda_drv & (sda_oe_b | sda_out); // open drain with pull-up
  wire logic [7:0] now = {4'h0, powered_down, led_drive_hi, als_range_hi, visible_or_infrared_select};
  int error_cnt = 0, tests_run = 0, cyc = 0, led_w = 0, led_last = 0, prox_n = 0;
  lpp_power_init_control dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_drv), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .led_drive_pin(led_drive_pin), .led_drive_hi(led_drive_hi),
    .als_range_hi(als_range_hi), .visible_or_infrared_select(visible_or_infrared_select),
    .als_conv_start(als_conv_start), .prox_conv_start(prox_conv_start), .powered_down(powered_down),
    .reinit_seen(reinit_seen));
  lpp_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // expected decode of a configuration byte
  function automatic logic [7:0] outs(input logic [7:0] c);
    return {4'h0, !(c[7] | c[2]), c[3], c[1], c[0]};
  endfunction
  task automatic complete_run();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always #5 clk_sys = ~clk_sys;
  // led width and prox strobe tally, plus hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (led_drive_pin) led_w <= led_w + 1;
    else if (led_w != 0) begin
      led_last <= led_w;
      led_w <= 0;
    end
    if (prox_conv_start) prox_n <= prox_n + 1;
    if (cyc == 300000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    logic [7:0] c, r;
    logic ok;
    void'($urandom(36331));
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    host.tick(3);
    chk(now, outs(8'h00));
    chk({3'h0, reinit_seen, sda_oe_b, led_drive_pin, als_conv_start, prox_conv_start}, 8'h08);
    host.reinit();
    chk({7'h00, reinit_seen}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : 8'($urandom()) & 8'h7F;
      host.wr(TARGET_ADDR, SENSING_CONFIGURATION_OFS, c, ok);
      chk({7'h00, ok}, 8'h01);
      chk(now, outs(c));
      host.rd(SENSING_CONFIGURATION_OFS, r);
      chk(r, c);
    end
    chk({7'h00, reinit_seen}, 8'h00);
    host.rd(TEST_CONTROL_TWO_OFS, r);
    chk(r, 8'h00);
    host.wr(TARGET_ADDR ^ (7'h01 << ($urandom() % 7)), SENSING_CONFIGURATION_OFS, 8'h84, ok);
    chk({7'h00, ok}, 8'h00);
    chk(now, outs(c));
    host.wr(TARGET_ADDR, SENSING_CONFIGURATION_OFS, 8'h80, ok);
    host.tick(LED_PULSE_CYC + 500);
    chk({7'h00, led_last == LED_PULSE_CYC}, 8'h01);
    chk(8'(prox_n), 8'h01);
    host.wr(TARGET_ADDR, SENSING_CONFIGURATION_OFS, 8'h00, ok);
    host.tick(2000);
    chk({6'h00, led_drive_pin, powered_down}, 8'h01);
    chk(8'(prox_n), 8'h01);
    // mid-run reset must drop the configuration back to powered-down
    host.wr(TARGET_ADDR, SENSING_CONFIGURATION_OFS, 8'h04, ok);
    chk(now, outs(8'h04));
    rst_b = 1'b0;
    host.tick(2);
    rst_b = 1'b1;
    host.tick(3);
    chk(now, outs(8'h00));
    host.rd(SENSING_CONFIGURATION_OFS, r);
    chk(r, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
